// >>> logic/sacs_sequencer.sv
`default_nettype none
// conversion sequencer of a successive-approximation converter
module sacs_sequencer #(
   parameter int unsigned WIDTH = 12
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic rd_conv,
   input wire logic bipolar,
   input wire logic comp_below,
   output logic conv_clk_en,
   output logic sample_hold,
   output logic [11:0] dac_code,
   output logic conversion_status,
   output logic eoc,
   output sacs_pkg::sacs_out_t host_out
);
   // ==========================================
   // elaboration checks
   if (WIDTH != sacs_pkg::RES_BITS) begin : g_chk
      $error("width must equal converter resolution");
   end

   // ==========================================
   // state
   sacs_pkg::sacs_state_t state_r; // sequencer state
   logic rd_conv_r;                // previous level for edge detect
   logic [3:0] step_r;             // bit index under trial
   logic acq_cnt_r;                // acquisition cycle count
   logic [11:0] sar_q;             // approximation register
   logic [11:0] result_r;          // last completed result
   logic [11:0] trial_vec;         // one-hot trial bit
   logic start;                    // falling edge of read/convert
   logic clear_sar;                // register clear on start
   logic decide;                   // comparator decision strobe

   assign start = rd_conv_r && !rd_conv;
   assign clear_sar = (state_r == sacs_pkg::SACS_IDLE) && start;
   assign decide = (state_r == sacs_pkg::SACS_CONV);

   // ==========================================
   // edge detector
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_conv_r <= 1'b1;
      end else begin
         rd_conv_r <= rd_conv;
      end
   end

   // ==========================================
   // main sequence
   // start only sampled in idle, so a running cycle cannot restart
   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= sacs_pkg::SACS_IDLE;
         acq_cnt_r <= 1'b0;
         step_r <= 4'h0;
      end else begin
         unique case (state_r)
            sacs_pkg::SACS_IDLE: begin
               if (start) begin
                  state_r <= sacs_pkg::SACS_ACQ;
                  acq_cnt_r <= 1'b0;
               end
            end
            sacs_pkg::SACS_ACQ: begin
               // second acquisition cycle ends the window
               acq_cnt_r <= 1'b1;
               if (acq_cnt_r == 1'(sacs_pkg::ACQ_CYCLES - 1)) begin
                  state_r <= sacs_pkg::SACS_CONV;
                  step_r <= 4'(WIDTH - 1);
               end
            end
            sacs_pkg::SACS_CONV: begin
               if (step_r == 4'h0) begin
                  state_r <= sacs_pkg::SACS_DONE;
               end else begin
                  step_r <= step_r - 4'h1;
               end
            end
            sacs_pkg::SACS_DONE: begin
               state_r <= sacs_pkg::SACS_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // trial vector: only the bit under test, zero outside the bit steps
   always_comb begin
      trial_vec = 12'h000;
      if (state_r == sacs_pkg::SACS_CONV) begin
         trial_vec[step_r] = 1'b1;
      end
   end

   // ==========================================
   // register bits, one cell each
   // the cell sets its bit when entering its step, decides at the step's end
   logic [11:0] set_vec; // trial strobes
   always_comb begin
      set_vec = 12'h000;
      if (state_r == sacs_pkg::SACS_ACQ && acq_cnt_r) begin
         set_vec[11] = 1'b1; // msb tried first
      end else if (state_r == sacs_pkg::SACS_CONV && step_r != 4'h0) begin
         set_vec[step_r - 4'h1] = 1'b1;
      end
   end

   // ==========================================
   // next register value, mirrored onto the dac pins
   // the dac must show the decided bits plus the new trial bit in the very
   // cycle the comparator is read; copying the old register instead would
   // leave a rejected bit set for one more comparison
   logic [11:0] sar_nxt; // register contents after this edge
   always_comb begin
      sar_nxt = sar_q;
      if (clear_sar) begin
         sar_nxt = sacs_pkg::SAR_RESET;
      end else begin
         if (decide && !comp_below) begin
            sar_nxt = sar_q & ~trial_vec;
         end
         sar_nxt = sar_nxt | set_vec;
      end
   end

   for (genvar i = 0; i < 12; i++) begin : g_bit
      sacs_sar_bit u_bit (
         .clk(clk),
         .srst(srst),
         .clear(clear_sar),
         .trial(set_vec[i]),
         .decide(decide && trial_vec[i]),
         .keep(comp_below),
         .q(sar_q[i])
      );
   end

   // ==========================================
   // outputs to the analog side
   always_ff @(posedge clk) begin
      if (srst) begin
         conv_clk_en <= 1'b0;
         sample_hold <= 1'b0;
         dac_code <= sacs_pkg::SAR_RESET;
         eoc <= 1'b0;
      end else begin
         // clock runs from start until the last decision
         conv_clk_en <= clear_sar ||
            (conv_clk_en && !(state_r == sacs_pkg::SACS_CONV && step_r == 4'h0));
         sample_hold <= (state_r == sacs_pkg::SACS_ACQ && acq_cnt_r) ||
            (sample_hold && state_r != sacs_pkg::SACS_DONE);
         dac_code <= sar_nxt;
         eoc <= (state_r == sacs_pkg::SACS_CONV) && (step_r == 4'h0);
      end
   end

   // ==========================================
   // status and result capture
   // bipolar offset-binary is the raw code; the analog offset shifts the input
   always_ff @(posedge clk) begin
      if (srst) begin
         conversion_status <= 1'b0;
         result_r <= sacs_pkg::SAR_RESET;
      end else begin
         if (clear_sar) begin
            conversion_status <= 1'b1;
            result_r <= sacs_pkg::SAR_RESET;
         end else if (state_r == sacs_pkg::SACS_DONE) begin
            conversion_status <= 1'b0;
            result_r <= sar_q;
         end
      end
   end

   // ==========================================
   // host output buffers
   // enabled only when line high and not converting, one cycle after status drops
   always_ff @(posedge clk) begin
      if (srst) begin
         host_out <= '0;
      end else begin
         host_out.data <= result_r;
         host_out.data_oe <= rd_conv && !conversion_status &&
            state_r == sacs_pkg::SACS_IDLE;
      end
   end

   // ==========================================
   // checks
   // properties are grouped by rule after all of the logic; all share clk and srst

   // ==========================================
   // start and sequencing

   // a start must leave a cleared register and a busy status
   AST_START_CLEAR: assert property (@(posedge clk) disable iff (srst)
      clear_sar |=> (sar_q == 12'h000) && conversion_status)
      else $error("start did not clear register");

   // the conversion clock runs through acquisition and every bit step
   AST_CLK_ON: assert property (@(posedge clk) disable iff (srst)
      (state_r == sacs_pkg::SACS_ACQ || state_r == sacs_pkg::SACS_CONV) |-> conv_clk_en)
      else $error("conversion clock off while running");

   // a second start edge must not disturb the step count
   AST_NO_RESTART: assert property (@(posedge clk) disable iff (srst)
      (state_r == sacs_pkg::SACS_CONV && step_r != 4'h0) |=>
      (state_r == sacs_pkg::SACS_CONV) && (step_r == $past(step_r) - 4'h1))
      else $error("restart in cycle");

   // exactly two acquisition cycles, then the first bit step
   AST_ACQ_TWO: assert property (@(posedge clk) disable iff (srst)
      clear_sar |=> state_r == sacs_pkg::SACS_ACQ ##1 state_r == sacs_pkg::SACS_ACQ
      ##1 state_r == sacs_pkg::SACS_CONV) else $error("acquisition not two cycles");

   // the sample is still open during the second acquisition cycle
   AST_ACQ_OPEN: assert property (@(posedge clk) disable iff (srst)
      (state_r == sacs_pkg::SACS_ACQ && !acq_cnt_r) |=> !sample_hold)
      else $error("sample held too early");

   // the sample stays held while bits are tried
   AST_HOLD_CONV: assert property (@(posedge clk) disable iff (srst)
      (state_r == sacs_pkg::SACS_CONV) |-> sample_hold)
      else $error("sample released during conversion");

   // twelve internally timed steps from first trial to end flag
   AST_CONV_LEN: assert property (@(posedge clk) disable iff (srst)
      $rose(state_r == sacs_pkg::SACS_CONV) |-> ##12 eoc)
      else $error("conversion not twelve steps");

   // ==========================================
   // approximation register

   // the msb is the first and only bit set when stepping begins
   AST_MSB_FIRST: assert property (@(posedge clk) disable iff (srst)
      $rose(state_r == sacs_pkg::SACS_CONV) |-> (step_r == 4'hb) && (sar_q == 12'h800))
      else $error("first trial is not the msb");

   // msb decision follows the comparator
   AST_KEEP_BIT: assert property (@(posedge clk) disable iff (srst)
      (decide && step_r == 4'hb) |=> sar_q[11] == $past(comp_below))
      else $error("msb decision wrong");

   // any trial bit stays set when the sum is below the input
   AST_KEEP_ANY: assert property (@(posedge clk) disable iff (srst)
      (decide && comp_below) |=> (sar_q & $past(trial_vec)) == $past(trial_vec))
      else $error("trial bit dropped although below");

   // any trial bit is cleared when the sum is above the input
   AST_DROP_ANY: assert property (@(posedge clk) disable iff (srst)
      (decide && !comp_below) |=> (sar_q & $past(trial_vec)) == 12'h000)
      else $error("trial bit kept although above");

   // the dac pins always show the register, so no decision lags a step
   AST_DAC_TRACKS: assert property (@(posedge clk) disable iff (srst)
      dac_code == sar_q)
      else $error("dac code differs from register");

   // in bipolar mode the first trial is the major carry code
   AST_MAJOR_CARRY: assert property (@(posedge clk) disable iff (srst)
      (bipolar && state_r == sacs_pkg::SACS_ACQ && acq_cnt_r) |=>
      (dac_code == sacs_pkg::MIDSCALE))
      else $error("first bipolar trial not at major carry");

   // ==========================================
   // end of conversion

   // the clock is gated off in the same cycle the end flag rises
   AST_CLK_OFF: assert property (@(posedge clk) disable iff (srst)
      eoc |-> !conv_clk_en)
      else $error("clock still on after end");

   // no conversion clock while idle
   AST_CLK_IDLE: assert property (@(posedge clk) disable iff (srst)
      (state_r == sacs_pkg::SACS_IDLE) |-> !conv_clk_en)
      else $error("clock running while idle");

   // the end flag lasts a single cycle
   AST_EOC_PULSE: assert property (@(posedge clk) disable iff (srst)
      eoc |=> !eoc)
      else $error("end flag longer than one cycle");

   // status drops right after the end flag
   AST_STATUS_LOW: assert property (@(posedge clk) disable iff (srst)
      eoc |=> !conversion_status)
      else $error("status not dropped");

   // status stays high from start until the sequence is back in idle
   AST_STATUS_BUSY: assert property (@(posedge clk) disable iff (srst)
      (state_r != sacs_pkg::SACS_IDLE) |-> conversion_status)
      else $error("status low while converting");

   // ==========================================
   // host output buffers

   // buffers stay off one cycle behind a busy status
   AST_NO_OE_BUSY: assert property (@(posedge clk) disable iff (srst)
      conversion_status |=> !host_out.data_oe)
      else $error("data driven while busy");

   // buffers stay off while the sequence runs
   AST_OE_IDLE: assert property (@(posedge clk) disable iff (srst)
      (state_r != sacs_pkg::SACS_IDLE) |=> !host_out.data_oe)
      else $error("data driven outside idle");

   // buffers only follow a high read/convert line and a low status
   AST_OE_LEVEL: assert property (@(posedge clk) disable iff (srst)
      host_out.data_oe |-> $past(rd_conv) && !$past(conversion_status))
      else $error("data driven without read request");

   // the finished result reaches the buffers once status has dropped
   AST_DATA_RESULT: assert property (@(posedge clk) disable iff (srst)
      $fell(conversion_status) |=> host_out.data == $past(result_r))
      else $error("result not presented after end");

   // the result stays put while idle until a new start
   AST_RESULT_HOLD: assert property (@(posedge clk) disable iff (srst)
      (state_r == sacs_pkg::SACS_IDLE && !clear_sar) |=> $stable(result_r))
      else $error("result changed while idle");
endmodule // sacs_sequencer
`default_nettype wire

// >>> logic/sacs_pkg.sv
`default_nettype none
package sacs_pkg;
   // ==========================================
   // sizes and counts
   localparam int unsigned RES_BITS = 12;       // converter resolution
   localparam int unsigned ACQ_CYCLES = 2;      // acquisition_window length in clocks
   localparam logic [11:0] SAR_RESET = 12'h000; // register value on start
   localparam logic [11:0] MIDSCALE = 12'h800;  // offset-binary major carry code

   // ==========================================
   // sequencer states, gray along the usual path
   typedef enum logic [1:0] {
      SACS_IDLE = 2'b00,
      SACS_ACQ = 2'b01,
      SACS_CONV = 2'b11,
      SACS_DONE = 2'b10
   } sacs_state_t;

   // ==========================================
   // host-facing result bundle
   typedef struct packed {
      logic [11:0] data;   // left-justified result
      logic data_oe;       // output buffers driving
   } sacs_out_t;
endpackage
`default_nettype wire

// >>> logic/sacs_sar_bit.sv
`default_nettype none
// one trial bit of the approximation register
module sacs_sar_bit (
   input wire logic clk,
   input wire logic srst,
   input wire logic clear,
   input wire logic trial,
   input wire logic decide,
   input wire logic keep,
   output logic q
);
   // ==========================================
   // bit storage
   // clear wins so a new start always begins from zero
   always_ff @(posedge clk) begin
      if (srst || clear) begin
         q <= 1'b0;
      end else if (trial) begin
         q <= 1'b1;
      end else if (decide) begin
         q <= keep;
      end
   end
endmodule // sacs_sar_bit
`default_nettype wire

// >>> sim/sacs_comparator_model.sv
`default_nettype none
// ==========================================
// comparator of the far side, ideal and instant
module sacs_comparator_model (
   input wire logic [11:0] dac_code,
   input wire logic [11:0] vin,
   output logic comp_below
);
   timeunit 1ns;
   timeprecision 100ps;
   // input sits mid-code, so equal trial sum still counts as below
   assign comp_below = (dac_code <= vin);
endmodule // sacs_comparator_model
`default_nettype wire

// >>> sim/sacs_sequencer_tb.sv
`default_nettype none
// ==========================================
// bench of the conversion sequencer
module sacs_sequencer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0; // 250 MHz
   logic srst = 1'b1; // held at start
   logic rd_conv = 1'b1; // host read/convert line
   logic bipolar = 1'b0; // range mode
   logic comp_below; // from comparator model
   logic conv_clk_en, sample_hold, conversion_status, eoc;
   logic [11:0] dac_code; // trial code
   logic [11:0] vin = 12'h000; // analog input as ideal code
   sacs_pkg::sacs_out_t host_out; // result bundle
   int bad_count = 0;
   int n_tests = 0;
   int seed = 32'h1207; // fixed for repeatable runs
   // ==========================================
   // clock
   initial begin
      forever #2 clk = ~clk;
   end
   sacs_sequencer #(.WIDTH(12)) u_sacs_sequencer (
      .clk(clk), .srst(srst), .rd_conv(rd_conv), .bipolar(bipolar),
      .comp_below(comp_below), .conv_clk_en(conv_clk_en),
      .sample_hold(sample_hold), .dac_code(dac_code),
      .conversion_status(conversion_status), .eoc(eoc), .host_out(host_out)
   );
   sacs_comparator_model u_sacs_comparator_model (
      .dac_code(dac_code), .vin(vin), .comp_below(comp_below)
   );
   // ==========================================
   // compare and count
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
      n_tests++;
      if (e !== s) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   // verdict and end of run
   task automatic print_verdict;
      $display("tests %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ideal result: the input code itself, left-justified
   function automatic logic [11:0] expect_code(input logic [11:0] v);
      return v;
   endfunction
   // ==========================================
   // one conversion; glitch pulses the start line mid-cycle
   task automatic conv(input logic [11:0] v, input logic glitch);
      int n;
      logic [11:0] e;
      n = 0;
      e = expect_code(v);
      vin = v;
      bipolar = 1'($random(seed));
      rd_conv = 1'b0; // falling edge starts
      @(posedge clk) #1;
      while (eoc !== 1'b1 && n < 30) begin
         @(posedge clk) #1;
         n++;
         if (glitch && n == 4) rd_conv = 1'b1;
         if (glitch && n == 6) rd_conv = 1'b0; // second start, ignored
         if (n == 1) begin
            chk("trial_clear", 12'h000, dac_code);
            chk("acq_open", 12'h000, {11'h0, sample_hold});
         end
         if (n == 2) begin
            chk("msb_trial", sacs_pkg::MIDSCALE, dac_code);
         end
         if (eoc !== 1'b1) begin
            chk("clk_on", 12'h001, {11'h0, conv_clk_en});
            chk("status", 12'h001, {11'h0, conversion_status});
            chk("oe_busy", 12'h000, {11'h0, host_out.data_oe});
            chk("data_busy", 12'h000, host_out.data);
         end
      end
      chk("eoc_seen", 12'h001, {11'h0, eoc});
      chk("held", 12'h001, {11'h0, sample_hold});
      @(posedge clk) #1;
      chk("clk_off", 12'h000, {11'h0, conv_clk_en});
      chk("status_lo", 12'h000, {11'h0, conversion_status});
      chk("oe_early", 12'h000, {11'h0, host_out.data_oe});
      rd_conv = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("result", e, host_out.data);
      chk("oe", 12'h001, {11'h0, host_out.data_oe});
      repeat (3) @(posedge clk);
      #1;
      chk("kept", e, host_out.data);
      $display("conversion of %h done", v);
   endtask
   // reset cuts a running conversion; all must be idle afterwards
   task automatic conv_reset;
      rd_conv = 1'b0; // start, later cut by reset
      repeat (6) @(posedge clk);
      #1;
      srst = 1'b1;
      rd_conv = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      srst = 1'b0;
      chk("rst_status", 12'h000, {11'h0, conversion_status});
      chk("rst_clk", 12'h000, {11'h0, conv_clk_en});
      chk("rst_oe", 12'h000, {11'h0, host_out.data_oe});
      @(posedge clk) #1;
      $display("reset during conversion done");
   endtask
   // ==========================================
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      #1;
      srst = 1'b0;
      @(posedge clk) #1;
      conv(12'h000, 1'b0);
      conv(12'hfff, 1'b1);
      conv(12'h7ff, 1'b0);
      conv(12'h800, 1'b1);
      repeat (20) begin
         conv(12'($random(seed)), 1'($random(seed)));
      end
      conv_reset();
      conv(12'h5a5, 1'b1);
      print_verdict();
   end
   // watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
endmodule // sacs_sequencer_tb
`default_nettype wire
